// ==== common/lbt_pkg.sv ====
package lbt_pkg;
   // Register byte offsets
   localparam logic [7:0] OFF_CTRL  = 8'h00;
   localparam logic [7:0] OFF_CMD   = 8'h04;
   localparam logic [7:0] OFF_STAT  = 8'h08;
   localparam logic [7:0] OFF_BER   = 8'h0c;
   localparam logic [7:0] OFF_SLOSS = 8'h10;
   localparam logic [7:0] OFF_ERR   = 8'h14;
   localparam logic [7:0] OFF_BITS  = 8'h18;
   localparam logic [7:0] OFF_EFS   = 8'h1c;
   localparam logic [7:0] OFF_ESEC  = 8'h20;
   localparam logic [7:0] OFF_TSEC  = 8'h24;
   // Control register fields
   localparam int CTRL_W  = 8;
   localparam int B_TER   = 0;
   localparam int B_SAT   = 1;
   localparam int B_IF    = 2;
   localparam int B_DIR   = 3;
   localparam int GEN_LO  = 4;
   localparam int CHK_LO  = 6;
   localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;
   // Command register fields
   localparam int B_INS   = 0;
   localparam int B_RST   = 1;
   // Status fields and BER value layout
   localparam int B_LOCK  = 0;
   localparam int B_BUSY  = 1;
   localparam int EXP_LO  = 16;
   // Pattern selections
   localparam logic [1:0] PAT_OFF  = 2'h0;
   localparam logic [1:0] PAT_2047 = 2'h1;
   localparam logic [1:0] PAT_23   = 2'h2;
   localparam logic [22:0] SEED    = 23'h7fffff;
   // Checker sync criteria
   localparam logic [6:0] SYNC_RUN = 7'h40;
   localparam logic [6:0] WIN_END  = 7'h7f;
   localparam logic [6:0] LOSS_ERR = 7'h19;
   // Timing: one second at the 10 MHz bus clock
   localparam int CLK_HZ    = 10000000;
   localparam int SEC_S     = 1;
   localparam int SEC_CYC   = SEC_S * CLK_HZ;
   // Result scaling
   localparam logic [31:0] CNT_MAX  = 32'hffffffff;
   localparam logic [13:0] EFS_FULL = 14'h2710;
   localparam logic [63:0] EFS_MUL  = 64'h2710;
   localparam logic [63:0] DEC      = 64'h000a;
   localparam logic [63:0] MANT_MUL = 64'h03e8;
   localparam logic [5:0]  EXP_MAX  = 6'h3f;
endpackage

// ==== hw/lbt_tester.sv ====
`timescale 1ns/10ps
module lbt_tester #(
   parameter int SEC_CYCLES = lbt_pkg::SEC_CYC
) (
   input  wire logic                       hclk,
   input  wire logic                       hresetn,
   input  wire logic                       hsel,
   input  wire logic [31:0]                haddr,
   input  wire logic [1:0]                 htrans,
   input  wire logic                       hwrite,
   input  wire logic [2:0]                 hsize,
   input  wire logic [31:0]                hwdata,
   input  wire logic                       hready,
   output logic                            hreadyout,
   output logic                            hresp,
   output logic [31:0]                     hrdata,
   input  wire logic                       panel_wr,
   input  wire logic [lbt_pkg::CTRL_W-1:0] panel_ctrl,
   input  wire logic                       panel_restart,
   input  wire logic                       panel_insert,
   input  wire logic                       nv_restore,
   input  wire logic [lbt_pkg::CTRL_W-1:0] nv_ctrl_in,
   output logic [lbt_pkg::CTRL_W-1:0]      nv_ctrl_out,
   input  wire logic                       ter_in_data,
   input  wire logic                       ter_in_valid,
   input  wire logic                       ter_out_req,
   output logic                            ter_out_data,
   output logic                            ter_out_valid,
   input  wire logic                       dem_data,
   input  wire logic                       dem_valid,
   input  wire logic                       mod_req,
   output logic                            mod_data,
   output logic                            mod_valid,
   input  wire logic                       rx_buffer_enabled,
   output logic                            rx_buffer_engaged,
   output logic                            mod_timing_from_demod,
   output logic                            if_loopback
);
   import lbt_pkg::*;

   typedef enum logic {CK_HUNT, CK_LOCK} lbt_chk_t;
   typedef enum logic [1:0] {BR_IDLE, BR_SCALE, BR_DIV} lbt_ber_t;

   logic [CTRL_W-1:0] ctrl;
   logic              ap_wr;
   logic [7:0]        ap_addr;
   logic [31:0]       rd_mux;
   logic              bus_ctrl_wr;
   logic              restart;
   logic              ins_pend;
   logic [22:0]       gen_lfsr;
   logic [22:0]       chk_lfsr;
   lbt_chk_t          chk_st;
   logic [6:0]        run_cnt;
   logic [6:0]        win_cnt;
   logic [6:0]        win_err;
   logic [31:0]       sloss_cnt;
   logic [31:0]       err_cnt;
   logic [31:0]       bits_cnt;
   logic [31:0]       esec_cnt;
   logic [31:0]       tsec_cnt;
   logic [13:0]       efs;
   logic [31:0]       sec_div;
   logic              sec_bad;
   lbt_ber_t          ber_st;
   logic [63:0]       ber_num;
   logic [31:0]       ber_den;
   logic [5:0]        ber_exp;
   logic [13:0]       ber_mant;
   logic [5:0]        ber_exp_out;

   wire ter_loop = ctrl[B_TER];
   wire sat_loop = ctrl[B_SAT];
   wire dir_ter  = ctrl[B_DIR];
   wire [1:0] gen_pat = ctrl[GEN_LO +: 2];
   wire [1:0] chk_pat = ctrl[CHK_LO +: 2];
   wire gen_on = (gen_pat != PAT_OFF);
   wire chk_on = (chk_pat != PAT_OFF);

   // Shared pattern feedback for both generator and checker
   function automatic logic lbt_fb(input logic [1:0] p,
                                   input logic [22:0] s);
      lbt_fb = (p == PAT_2047) ? (s[10] ^ s[8]) : (s[22] ^ s[17]);
   endfunction

   // Saturating increment, so long tests never wrap to small values
   function automatic logic [31:0] lbt_inc(input logic [31:0] c);
      lbt_inc = (c == CNT_MAX) ? c : c + 32'h1;
   endfunction

   // Generator and checker bit streams, chosen by direction
   wire gen_adv = gen_on && (dir_ter ? (ter_out_req && !ter_loop)
                                     : (mod_req && !sat_loop));
   wire gen_bit = lbt_fb(gen_pat, gen_lfsr) ^ ins_pend;
   wire chk_v   = chk_on && (dir_ter ? (ter_in_valid && !ter_loop)
                                     : (dem_valid && !sat_loop));
   wire chk_d   = dir_ter ? ter_in_data : dem_data;
   wire chk_prd = lbt_fb(chk_pat, chk_lfsr);
   wire locked  = (chk_st == CK_LOCK);
   wire bit_err = chk_v && locked && (chk_d != chk_prd);
   wire [6:0] win_sum = win_err + {6'h00, bit_err};
   wire loss_evt = chk_v && locked && (win_cnt == WIN_END) &&
                   (win_sum >= LOSS_ERR);
   wire sec_tick = chk_on && (sec_div == 32'(SEC_CYCLES - 1));

   // AHB-Lite: zero wait states, always OKAY
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   wire ap_take = hsel && htrans[1] && hready;
   wire dp_wr   = ap_wr;

   // Address phase capture for the write data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_wr   <= 1'b0;
         ap_addr <= 8'h00;
      end else begin
         ap_wr   <= ap_take && hwrite;
         ap_addr <= haddr[7:0];
      end
   end

   // Read mux; unmapped offsets read as zero
   always_comb begin
      rd_mux = 32'h0;
      case (haddr[7:0])
         OFF_CTRL:  rd_mux[CTRL_W-1:0] = ctrl;
         OFF_STAT: begin
            rd_mux[B_LOCK] = locked;
            rd_mux[B_BUSY] = (ber_st != BR_IDLE);
         end
         OFF_BER: begin
            rd_mux[13:0] = ber_mant;
            rd_mux[EXP_LO +: 6] = ber_exp_out;
         end
         OFF_SLOSS: rd_mux = sloss_cnt;
         OFF_ERR:   rd_mux = err_cnt;
         OFF_BITS:  rd_mux = bits_cnt;
         OFF_EFS:   rd_mux[13:0] = efs;
         OFF_ESEC:  rd_mux = esec_cnt;
         OFF_TSEC:  rd_mux = tsec_cnt;
         default:   rd_mux = 32'h0;
      endcase
   end

   // Read data is sampled at the address phase and held in a flop
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         hrdata <= 32'h0;
      else if (ap_take && !hwrite)
         hrdata <= rd_mux;
   end

   // Writing any result register restarts the whole measurement
   wire res_wr = dp_wr && (ap_addr == OFF_BER || ap_addr == OFF_SLOSS ||
                 ap_addr == OFF_ERR || ap_addr == OFF_BITS ||
                 ap_addr == OFF_EFS || ap_addr == OFF_ESEC ||
                 ap_addr == OFF_TSEC);
   wire cmd_wr = dp_wr && (ap_addr == OFF_CMD);
   assign restart = res_wr || (cmd_wr && hwdata[B_RST]) ||
                    panel_restart;
   assign bus_ctrl_wr = dp_wr && (ap_addr == OFF_CTRL);

   // Control: bus beats panel, panel beats nonvolatile restore
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         ctrl <= CTRL_RST;
      else if (bus_ctrl_wr)
         ctrl <= hwdata[CTRL_W-1:0];
      else if (panel_wr)
         ctrl <= panel_ctrl;
      else if (nv_restore) begin
         ctrl[B_IF]         <= nv_ctrl_in[B_IF];
         ctrl[B_DIR]        <= nv_ctrl_in[B_DIR];
         ctrl[GEN_LO +: 2]  <= nv_ctrl_in[GEN_LO +: 2];
         ctrl[CHK_LO +: 2]  <= nv_ctrl_in[CHK_LO +: 2];
      end
   end

   // State to be saved across power loss; other loops restart off
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         nv_ctrl_out <= CTRL_RST;
      else
         nv_ctrl_out <= ctrl & ~(CTRL_W'(1) << B_TER) &
                        ~(CTRL_W'(1) << B_SAT);
   end

   // Loop and timing controls toward the analog and clock logic
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         if_loopback           <= 1'b0;
         mod_timing_from_demod <= 1'b0;
         rx_buffer_engaged     <= 1'b0;
      end else begin
         if_loopback           <= ctrl[B_IF];
         mod_timing_from_demod <= sat_loop;
         rx_buffer_engaged     <= rx_buffer_enabled;
      end
   end

   // Toward modulator: loop, then generator, then terrestrial traffic
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mod_data  <= 1'b0;
         mod_valid <= 1'b0;
      end else if (sat_loop) begin
         mod_data  <= dem_data;
         mod_valid <= dem_valid;
      end else if (gen_on && !dir_ter) begin
         mod_data  <= gen_bit;
         mod_valid <= mod_req;
      end else begin
         mod_data  <= ter_in_data;
         mod_valid <= ter_in_valid;
      end
   end

   // Toward terrestrial side; satellite loop returns nothing here
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ter_out_data  <= 1'b0;
         ter_out_valid <= 1'b0;
      end else if (ter_loop) begin
         ter_out_data  <= ter_in_data;
         ter_out_valid <= ter_in_valid;
      end else if (sat_loop) begin
         ter_out_data  <= 1'b0;
         ter_out_valid <= 1'b0;
      end else if (gen_on && dir_ter) begin
         ter_out_data  <= gen_bit;
         ter_out_valid <= ter_out_req;
      end else begin
         ter_out_data  <= dem_data;
         ter_out_valid <= dem_valid;
      end
   end

   // Pattern generator, free of the checker
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         gen_lfsr <= SEED;
      else if (!gen_on)
         gen_lfsr <= SEED;
      else if (gen_adv)
         gen_lfsr <= {gen_lfsr[21:0], lbt_fb(gen_pat, gen_lfsr)};
   end

   // Single error: armed by command, consumed by the next generated bit
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         ins_pend <= 1'b0;
      else if (!gen_on)
         ins_pend <= 1'b0;
      else if ((cmd_wr && hwdata[B_INS]) || panel_insert)
         ins_pend <= 1'b1;
      else if (gen_adv)
         ins_pend <= 1'b0;
   end

   // Checker: hunt by loading received bits, lock after a clean run.
   // Restart keeps sync, so a clean link restarts at full EFS
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         chk_st   <= CK_HUNT;
         chk_lfsr <= SEED;
         run_cnt  <= 7'h00;
         win_cnt  <= 7'h00;
         win_err  <= 7'h00;
      end else if (!chk_on) begin
         chk_st  <= CK_HUNT;
         run_cnt <= 7'h00;
      end else if (chk_v) begin
         case (chk_st)
            CK_HUNT: begin
               chk_lfsr <= {chk_lfsr[21:0], chk_d};
               run_cnt  <= (chk_d == chk_prd) ? run_cnt + 7'h01 : 7'h00;
               win_cnt  <= 7'h00;
               win_err  <= 7'h00;
               if (chk_d == chk_prd && run_cnt == SYNC_RUN - 7'h01)
                  chk_st <= CK_LOCK;
            end
            CK_LOCK: begin
               chk_lfsr <= {chk_lfsr[21:0], chk_prd};
               win_cnt  <= win_cnt + 7'h01;
               win_err  <= (win_cnt == WIN_END) ? 7'h00 : win_sum;
               run_cnt  <= 7'h00;
               if (loss_evt)
                  chk_st <= CK_HUNT;
            end
            default: chk_st <= CK_HUNT;
         endcase
      end
   end

   // Bit-level result counters
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sloss_cnt <= 32'h0;
         err_cnt   <= 32'h0;
         bits_cnt  <= 32'h0;
      end else if (restart) begin
         sloss_cnt <= 32'h0;
         err_cnt   <= 32'h0;
         bits_cnt  <= 32'h0;
      end else begin
         if (loss_evt)
            sloss_cnt <= lbt_inc(sloss_cnt);
         if (bit_err)
            err_cnt <= lbt_inc(err_cnt);
         if (chk_v)
            bits_cnt <= lbt_inc(bits_cnt);
      end
   end

   // One-second tick; restart realigns it to the new measurement
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         sec_div <= 32'h0;
      else if (restart || !chk_on || sec_tick)
         sec_div <= 32'h0;
      else
         sec_div <= sec_div + 32'h1;
   end

   // Seconds statistics; out-of-sync time marks the second errored
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sec_bad  <= 1'b0;
         esec_cnt <= 32'h0;
         tsec_cnt <= 32'h0;
      end else if (restart) begin
         sec_bad  <= 1'b0;
         esec_cnt <= 32'h0;
         tsec_cnt <= 32'h0;
      end else if (sec_tick) begin
         sec_bad  <= 1'b0;
         tsec_cnt <= lbt_inc(tsec_cnt);
         if (sec_bad || bit_err || !locked)
            esec_cnt <= lbt_inc(esec_cnt);
      end else if (chk_on && (bit_err || !locked)) begin
         sec_bad <= 1'b1;
      end
   end

   // Error-free percentage in hundredths; full when nothing elapsed
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         efs <= EFS_FULL;
      else if (restart || tsec_cnt == 32'h0)
         efs <= EFS_FULL;
      else
         efs <= 14'((64'(tsec_cnt - esec_cnt) * EFS_MUL) /
                    64'(tsec_cnt));
   end

   // Error ratio: scale errors by ten until they reach the bit count,
   // then one divide gives the mantissa; runs once each second
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ber_st      <= BR_IDLE;
         ber_num     <= 64'h0;
         ber_den     <= 32'h0;
         ber_exp     <= 6'h00;
         ber_mant    <= 14'h0000;
         ber_exp_out <= 6'h00;
      end else if (restart) begin
         ber_st      <= BR_IDLE;
         ber_mant    <= 14'h0000;
         ber_exp_out <= 6'h00;
      end else begin
         case (ber_st)
            BR_IDLE: begin
               if (sec_tick && err_cnt == 32'h0) begin
                  ber_mant    <= 14'h0000;
                  ber_exp_out <= 6'h00;
               end else if (sec_tick) begin
                  ber_num <= {32'h0, err_cnt};
                  ber_den <= bits_cnt;
                  ber_exp <= 6'h00;
                  ber_st  <= BR_SCALE;
               end
            end
            BR_SCALE: begin
               if (ber_num < {32'h0, ber_den} && ber_exp != EXP_MAX) begin
                  ber_num <= ber_num * DEC;
                  ber_exp <= ber_exp + 6'h01;
               end else begin
                  ber_st <= BR_DIV;
               end
            end
            BR_DIV: begin
               ber_mant    <= 14'((ber_num * MANT_MUL) /
                                  {32'h0, ber_den});
               ber_exp_out <= ber_exp;
               ber_st      <= BR_IDLE;
            end
            default: ber_st <= BR_IDLE;
         endcase
      end
   end

   ter_loop_a: assert property (@(posedge hclk) disable iff (!hresetn)
      ter_loop && ter_in_valid |=> ter_out_valid &&
      ter_out_data == $past(ter_in_data))
      else $error("terrestrial loop did not return data");

   sat_quiet_a: assert property (@(posedge hclk) disable iff (!hresetn)
      sat_loop && !ter_loop |=> !ter_out_valid)
      else $error("satellite loop leaked to terrestrial side");

   sat_return_a: assert property (@(posedge hclk) disable iff (!hresetn)
      sat_loop && dem_valid |=> mod_valid &&
      mod_data == $past(dem_data))
      else $error("satellite loop did not resend demod data");

   timing_slave_a: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(sat_loop) |=> mod_timing_from_demod)
      else $error("modulator timing not slaved in satellite loop");

   err_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
      !locked && !restart |=> err_cnt == $past(err_cnt))
      else $error("errors counted while out of sync");

   restart_clr_a: assert property (@(posedge hclk) disable iff (!hresetn)
      restart |=> sloss_cnt == 32'h0 && err_cnt == 32'h0 &&
      bits_cnt == 32'h0 && esec_cnt == 32'h0 && tsec_cnt == 32'h0 &&
      ber_mant == 14'h0000 ##1 efs == EFS_FULL)
      else $error("restart left a result uncleared");

   insert_once_a: assert property (@(posedge hclk) disable iff (!hresetn)
      ins_pend && gen_adv && !panel_insert && !cmd_wr
      |-> gen_bit != lbt_fb(gen_pat, gen_lfsr) ##1 !ins_pend)
      else $error("inserted error not exactly one bit");

   bit_count_a: assert property (@(posedge hclk) disable iff (!hresetn)
      chk_v && !restart && bits_cnt != CNT_MAX
      |=> bits_cnt == $past(bits_cnt) + 32'h1)
      else $error("received bit not counted");

   sec_count_a: assert property (@(posedge hclk) disable iff (!hresetn)
      sec_tick && !restart && tsec_cnt != CNT_MAX
      |=> tsec_cnt == $past(tsec_cnt) + 32'h1)
      else $error("elapsed second not counted");
endmodule

// ==== verification/lbt_far_side.sv ====
`timescale 1ns/10ps
// Far-side stand-in: modulator, demodulator and terrestrial line
module lbt_far_side (
   input  wire logic hclk,
   input  wire logic hresetn,
   input  wire logic mod_data,
   input  wire logic mod_valid,
   input  wire logic if_loopback,
   input  wire logic ter_out_data,
   input  wire logic ter_out_valid,
   input  wire logic line_echo,
   output logic      mod_req,
   output logic      ter_out_req,
   output logic      dem_data,
   output logic      dem_valid,
   output logic      ter_in_data,
   output logic      ter_in_valid
);
   logic [3:0] ph;
   // One bit each fourth cycle; idle data toggles so stale bits show
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph <= 4'h0;
         {mod_req, ter_out_req, dem_valid, ter_in_valid} <= 4'h0;
         dem_data <= 1'b0;
         ter_in_data <= 1'b0;
      end else begin
         ph <= ph + 4'h1;
         mod_req <= (ph[1:0] == 2'h0);
         ter_out_req <= (ph[1:0] == 2'h2);
         if (line_echo) begin // Line equipment hands our bits back
            ter_in_valid <= ter_out_valid;
            ter_in_data <= ter_out_valid ? ter_out_data : ~ter_in_data;
         end else begin
            ter_in_valid <= (ph[1:0] == 2'h1);
            ter_in_data <= (ph[1:0] == 2'h1) ? ph[2] ^ ph[3] : ~ter_in_data;
         end
         if (if_loopback) begin // Modulated signal back into demod
            dem_valid <= mod_valid;
            dem_data <= mod_valid ? mod_data : ~dem_data;
         end else begin
            dem_valid <= (ph[1:0] == 2'h3);
            dem_data <= (ph[1:0] == 2'h3) ? ph[3] : ~dem_data;
         end
      end
   end
endmodule

// ==== verification/lbt_tester_bench.sv ====
`timescale 1ns/10ps
// Bus tasks drive the registers; far-side model feeds the data path
module lbt_tester_bench;
   import lbt_pkg::*;
   logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic        panel_wr = 1'b0, nv_restore = 1'b0, last_ter = 1'b0;
   logic [1:0]  htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
   logic [7:0]  panel_ctrl = 8'h00, nv_ctrl_in = 8'h00, nv_ctrl_out;
   logic        hreadyout, hresp, ter_out_data, ter_out_valid, mod_data;
   logic        mod_valid, mod_req, ter_out_req, dem_data, dem_valid;
   logic        ter_in_data, ter_in_valid, rx_buffer_engaged, if_loopback;
   logic        mod_timing_from_demod;
   logic        panel_restart = 1'b0, panel_insert = 1'b0;
   logic        rx_buf_en = 1'b1, line_echo = 1'b0;
   int          n_mismatch = 0, total_checks = 0, mode = 0;
   always #50 hclk = ~hclk;
   // Short second keeps the seconds counters reachable
   lbt_tester #(.SEC_CYCLES(200)) dut (.hclk, .hresetn, .hsel, .haddr,
      .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
      .hreadyout, .hresp, .hrdata, .panel_wr, .panel_ctrl,
      .panel_restart, .panel_insert, .nv_restore, .nv_ctrl_in,
      .nv_ctrl_out, .ter_in_data, .ter_in_valid, .ter_out_req,
      .ter_out_data, .ter_out_valid, .dem_data, .dem_valid, .mod_req,
      .mod_data, .mod_valid, .rx_buffer_enabled(rx_buf_en), .rx_buffer_engaged,
      .mod_timing_from_demod, .if_loopback);
   lbt_far_side far (.hclk, .hresetn, .mod_data, .mod_valid, .if_loopback,
      .mod_req, .ter_out_req, .dem_data, .dem_valid, .ter_in_data,
      .ter_in_valid, .ter_out_data, .ter_out_valid, .line_echo);
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cyc(int n);
      repeat (n) @(posedge hclk);
   endtask
   // Single word; each phase held until hready is seen high
   task automatic xfer(logic w, logic [7:0] a, logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
      chk("hresp", 32'h0, 32'(hresp));
   endtask
   task automatic rd_chk(string nm, logic [7:0] a, logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk(nm, e, r);
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Watch what the loops hand back toward the terrestrial side
   always @(posedge hclk) begin
      if (ter_in_valid === 1'b1) last_ter <= ter_in_data;
      if (mode == 1 && ter_out_valid === 1'b1)
         chk("ter_loop", 32'(last_ter), 32'(ter_out_data));
      if (mode == 2) chk("sat_silent", 32'h0, 32'(ter_out_valid));
   end
   initial begin
      cyc(6);
      hresetn <= 1'b1;
      cyc(1);
      rd_chk("ctrl_rst", OFF_CTRL, 32'h0);
      rd_chk("efs_rst", OFF_EFS, 32'h2710);
      xfer(1'b1, 8'h28, 32'hffffffff);
      rd_chk("unmapped", 8'h28, 32'h0);
      $display("test reset_and_map done");
      nv_ctrl_in <= 8'hff;
      nv_restore <= 1'b1;
      cyc(1);
      nv_restore <= 1'b0;
      cyc(1);
      rd_chk("nv_restore", OFF_CTRL, 32'hfc);
      chk("nv_save", 32'hfc, 32'(nv_ctrl_out));
      panel_ctrl <= 8'h01;
      panel_wr <= 1'b1;
      cyc(1);
      panel_wr <= 1'b0;
      cyc(4);
      mode = 1;
      rd_chk("panel_wr", OFF_CTRL, 32'h01);
      cyc(200);
      mode = 0;
      $display("test nv_panel_ter_loop done");
      xfer(1'b1, OFF_CTRL, 32'h02);
      cyc(4);
      mode = 2;
      cyc(200);
      chk("mod_timing", 32'h1, 32'(mod_timing_from_demod));
      chk("rx_buf", 32'h1, 32'(rx_buffer_engaged));
      rx_buf_en <= 1'b0;
      cyc(2);
      chk("rx_buf_off", 32'h0, 32'(rx_buffer_engaged));
      mode = 0;
      $display("test sat_loop done");
      // Same pattern both ends, near loops other than IF left off
      xfer(1'b1, OFF_CTRL, 32'h54);
      cyc(1500);
      xfer(1'b1, OFF_ERR, 32'h0);
      cyc(4);
      xfer(1'b0, OFF_STAT, 32'h0);
      chk("locked", 32'h1, 32'(r[B_LOCK]));
      rd_chk("err_zero", OFF_ERR, 32'h0);
      chk("if_loop", 32'h1, 32'(if_loopback));
      xfer(1'b1, OFF_CMD, 32'h1);
      cyc(100);
      rd_chk("err_one", OFF_ERR, 32'h1);
      rd_chk("sloss", OFF_SLOSS, 32'h0);
      cyc(600);
      rd_chk("esec", OFF_ESEC, 32'h1);
      xfer(1'b0, OFF_BITS, 32'h0);
      chk("bits_nz", 32'h1, 32'(r != 32'h0));
      xfer(1'b0, OFF_TSEC, 32'h0);
      chk("tsec_nz", 32'h1, 32'(r != 32'h0));
      xfer(1'b0, OFF_EFS, 32'h0);
      chk("efs_low", 32'h1, 32'(r < 32'h2710));
      xfer(1'b0, OFF_BER, 32'h0);
      chk("ber_exp", 32'h3, 32'(r[EXP_LO +: 6]));
      chk("mant_lo", 32'h1, 32'(r[13:0] >= 14'h03e8));
      chk("mant_hi", 32'h1, 32'(r[13:0] < 14'h2710));
      xfer(1'b1, OFF_SLOSS, 32'h0);
      rd_chk("err_clr", OFF_ERR, 32'h0);
      rd_chk("esec_clr", OFF_ESEC, 32'h0);
      xfer(1'b0, OFF_BER, 32'h0);
      chk("mant_zero", 32'h0, 32'(r[13:0]));
      $display("test bert done");
      xfer(1'b1, OFF_CTRL, 32'h0);
      xfer(1'b1, OFF_CTRL, 32'ha4);
      cyc(600);
      xfer(1'b0, OFF_STAT, 32'h0);
      chk("lock_23", 32'h1, 32'(r[B_LOCK]));
      panel_restart <= 1'b1;
      cyc(1);
      panel_restart <= 1'b0;
      rd_chk("tsec_clr", OFF_TSEC, 32'h0);
      panel_insert <= 1'b1;
      cyc(1);
      panel_insert <= 1'b0;
      cyc(50);
      rd_chk("err_panel", OFF_ERR, 32'h1);
      $display("test long_pattern done");
      xfer(1'b1, OFF_CTRL, 32'h0);
      line_echo <= 1'b1;
      xfer(1'b1, OFF_CTRL, 32'h58);
      cyc(600);
      xfer(1'b0, OFF_STAT, 32'h0);
      chk("lock_ter", 32'h1, 32'(r[B_LOCK]));
      $display("test terrestrial_dir done");
      close_out();
   end
   initial begin
      cyc(20000);
      n_mismatch++;
      close_out();
   end
endmodule
